//--- mt_ctl_asserts.sv
/*
 Checker for the multithreaded global control register, bound to its top.
 Assumes one core clock and the asynchronous active-low reset.
*/
module mt_ctl_asserts
   import mt_ctl_pkg::*;
(
   // Clock, reset and access
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic master_vp_flag,
   input wire logic [CTX_W-1:0] req_ctx,
   input wire logic [31:0] mt_global_control_reg_q,
   input wire vp_op_type vp_op,
   // Cache and TLB
   input wire logic [NUM_VP*NUM_WAYS-1:0] icache_way_exclude,
   input wire logic [NUM_VP*NUM_WAYS-1:0] dcache_way_exclude,
   input wire logic [VP_ID_W-1:0] alloc_vp,
   input wire logic [NUM_WAYS-1:0] icache_alloc_mask_reg,
   input wire logic [NUM_WAYS-1:0] dcache_alloc_mask_reg,
   input wire logic [NUM_VP-1:0] vp_tlb_access,
   input wire logic [NUM_VP*TLB_IDX_W-1:0] vp_index,
   input wire logic [NUM_VP-1:0] vp_index_valid,
   input wire logic [TLB_IDX_W-1:0] wired_count,
   input wire logic [VP_ID_W-1:0] lookup_vp,
   input wire logic [ASID_W-1:0] lookup_asid,
   input wire logic [ASID_W+VP_ID_W-1:0] lookup_tag_reg,
   input wire logic [NUM_VP-1:0] full_tlb_vp_reg,
   input wire logic [TLB_IDX_W-1:0] random_tlb_write_index,
   // Issue control
   input wire logic multi_vp_enable_reg,
   input wire logic [CTX_W-1:0] sole_ctx_reg
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic acc;
   logic hit;
   logic [3:0] stab_cnt_reg;
   logic [NUM_VP*(TLB_IDX_W+2)+TLB_IDX_W-1:0] guard_in;
   logic [31:0] q;
   assign q = mt_global_control_reg_q;
   assign acc = clk_en && master_vp_flag;
   assign guard_in = {vp_index, vp_index_valid, vp_tlb_access, wired_count};
   always_comb begin
      hit = 1'b0;
      for (int v = 0; v < NUM_VP; v++) begin
         if (vp_tlb_access[v] && vp_index_valid[v]
             && random_tlb_write_index == vp_index[v*TLB_IDX_W +: TLB_IDX_W]) begin
            hit = 1'b1;
         end
      end
   end
   // The picker may stall on a held entry for a few cycles after the guards move,
   // and it cannot move at all while the clock enable is low.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stab_cnt_reg <= 4'h0;
      end else if (!clk_en || !$stable(guard_in) || !q[SHARE_BIT]) begin
         stab_cnt_reg <= 4'h0;
      end else if (stab_cnt_reg != 4'hF) begin
         stab_cnt_reg <= stab_cnt_reg + 4'h1;
      end
   end
   AST_RSVD_ZERO: assert property (q[31:18] == '0 && q[15:4] == '0)
      else $error("reserved bits not zero");
   AST_PART_OFF: assert property (!q[PART_BIT] |->
      icache_alloc_mask_reg == '1 && dcache_alloc_mask_reg == '1)
      else $error("exclusions not ignored");
   AST_PART_ON: assert property (q[PART_BIT] && $past(clk_en) |->
      icache_alloc_mask_reg == ~$past(icache_way_exclude[alloc_vp*NUM_WAYS +: NUM_WAYS])
      && dcache_alloc_mask_reg == ~$past(dcache_way_exclude[alloc_vp*NUM_WAYS +: NUM_WAYS]))
      else $error("exclusions not applied");
   AST_SHARE_LOCK: assert property (reg_wr && acc && !q[CONFIG_BIT] && !$past(reg_wr)
      && $past(clk_en) |=> ##1 q[SHARE_BIT] == $past(q[SHARE_BIT], 2))
      else $error("share bit changed while locked");
   AST_MASTER_ONLY: assert property ((reg_wr && clk_en && !master_vp_flag)
      ##1 (!reg_wr && vp_op == VP_OP_NONE) |=> $stable(q))
      else $error("write without master flag took effect");
   AST_ENABLE_OP: assert property (vp_op == VP_OP_ENABLE && acc |-> ##2 multi_vp_enable_reg)
      else $error("enable instruction ignored");
   AST_EN_COPY: assert property (multi_vp_enable_reg == q[ENABLE_BIT])
      else $error("enable output differs from register");
   AST_DISABLE_CTX: assert property (vp_op == VP_OP_DISABLE && acc |=>
      (!multi_vp_enable_reg || sole_ctx_reg == $past(req_ctx)) ##1 !multi_vp_enable_reg)
      else $error("disable did not record issuing context");
   AST_TAG_SHARED: assert property (clk_en |=> lookup_tag_reg[ASID_W-1:0] == $past(lookup_asid)
      && lookup_tag_reg[ASID_W +: VP_ID_W] == (q[SHARE_BIT] ? '0 : $past(lookup_vp)))
      else $error("lookup tag wrong");
   AST_FULL_TLB: assert property (clk_en |=>
      full_tlb_vp_reg == (q[SHARE_BIT] ? $past(vp_tlb_access) : '0))
      else $error("full TLB set wrong");
   AST_PICK_GUARD: assert property (q[SHARE_BIT] && stab_cnt_reg >= 4'h6 |-> !hit)
      else $error("random pick hits held index");
   cover property (vp_op == VP_OP_DISABLE && acc);
   cover property (stab_cnt_reg >= 4'h6);
   cover property (q[PART_BIT] && q[SHARE_BIT]);
endmodule : mt_ctl_asserts

bind mt_global_control_reg mt_ctl_asserts chk (.clk, .rst_n, .clk_en, .reg_wr, .master_vp_flag,
   .req_ctx, .mt_global_control_reg_q, .vp_op, .icache_way_exclude, .dcache_way_exclude,
   .alloc_vp, .icache_alloc_mask_reg, .dcache_alloc_mask_reg, .vp_tlb_access, .vp_index,
   .vp_index_valid, .wired_count, .lookup_vp, .lookup_asid, .lookup_tag_reg, .full_tlb_vp_reg,
   .random_tlb_write_index, .multi_vp_enable_reg, .sole_ctx_reg);

//--- mt_ctl_pkg.sv
/*
 Package for the multithreaded global control register: field positions,
 reset values, access codes and the TLB geometry used by the entry guard.
 Assumes a core clock and one asynchronous active-low processor reset.
*/
package mt_ctl_pkg;
   // ------------------------------------------------------------
   // Register field positions
   // ------------------------------------------------------------
   localparam int unsigned ENABLE_BIT = 0;
   localparam int unsigned CONFIG_BIT = 1;
   localparam int unsigned SHARE_BIT = 2;
   localparam int unsigned PART_BIT = 3;
   localparam int unsigned IMPL_LO = 16;
   localparam int unsigned IMPL_HI = 17;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic RST_ENABLE = 1'b0;
   localparam logic RST_CONFIG = 1'b0;
   localparam logic RST_SHARE = 1'b0;
   localparam logic RST_PART = 1'b0;
   localparam logic [1:0] RST_IMPL = 2'h0;
   // ------------------------------------------------------------
   // TLB and virtual processor geometry
   // ------------------------------------------------------------
   localparam int unsigned NUM_VP = 2;
   localparam int unsigned TLB_IDX_W = 5;
   localparam int unsigned NUM_WAYS = 4;
   localparam int unsigned CTX_W = 4;
   localparam int unsigned ASID_W = 8;
   // Virtual processor number width; the address space tag is asid plus vp number.
   localparam int unsigned VP_ID_W = 1;
   // ------------------------------------------------------------
   // Enable instruction codes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      VP_OP_NONE = 2'b00,
      VP_OP_ENABLE = 2'b01,
      VP_OP_DISABLE = 2'b10
   } vp_op_type;
endpackage : mt_ctl_pkg

//--- mt_global_control_reg.sv
/*
 Global control register of a multithreaded core with several virtual
 processors, with its effects on cache allocation, TLB sharing and issue.
 Assumes privileged register access strobes and index values arrive on clk.
*/
// Operation
// RULE1: Reserved fields read zero; software writes zeros to them.
// RULE2: Two-bit implementation field, meaning left to the processor.
// RULE3: Partition bit set lets way-exclusion fields steer cache allocation.
// RULE4: Partition bit clear makes allocation ignore all way-exclusion fields.
// RULE5: Shared-TLB bit changes only if configuration state was already set.
// RULE6: Sharing lets every TLB-capable processor use all entries, ignoring size.
// RULE7: Sharing unifies address and address-space tags across sharing processors.
// RULE8: Random writes never pick an entry held in a sharing valid index; the held pick can name one for a few cycles after the indexes change.
// RULE9: Software keeps unwired entries at least equal to sharing processors.
// RULE10: Software programs equal wired counts on all sharing processors.
// RULE11: Software programs segment control identically when sharing.
// RULE12: Software parks idle index registers invalid with probe failure set.
// RULE13: Configuration state bit unlocks preset fields; master processor only.
// RULE14: Enable bit set and cleared by instructions; master only; resets zero.
// RULE15: After disable only the issuing thread keeps issuing.
// RULE16: Software never sets configuration state and enable together.
// RULE17: Absent optional capabilities read zero and ignore writes.
module mt_global_control_reg
   import mt_ctl_pkg::*;
#(
   parameter bit HAS_PARTITION = 1'b1,
   parameter bit HAS_SHARE = 1'b1
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register access
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   input wire logic master_vp_flag,
   input wire logic [VP_ID_W-1:0] req_vp,
   input wire logic [CTX_W-1:0] req_ctx,
   output logic [31:0] mt_global_control_reg_q,
   // Enable instructions
   input wire vp_op_type vp_op,
   // Cache partitioning
   input wire logic [NUM_VP*NUM_WAYS-1:0] icache_way_exclude,
   input wire logic [NUM_VP*NUM_WAYS-1:0] dcache_way_exclude,
   input wire logic [VP_ID_W-1:0] alloc_vp,
   output logic [NUM_WAYS-1:0] icache_alloc_mask_reg,
   output logic [NUM_WAYS-1:0] dcache_alloc_mask_reg,
   // TLB
   input wire logic [NUM_VP-1:0] vp_tlb_access,
   input wire logic [NUM_VP*TLB_IDX_W-1:0] vp_index,
   input wire logic [NUM_VP-1:0] vp_index_valid,
   input wire logic [TLB_IDX_W-1:0] wired_count,
   input wire logic [VP_ID_W-1:0] lookup_vp,
   input wire logic [ASID_W-1:0] lookup_asid,
   output logic [ASID_W+VP_ID_W-1:0] lookup_tag_reg,
   output logic [NUM_VP-1:0] full_tlb_vp_reg,
   output logic [TLB_IDX_W-1:0] random_tlb_write_index,
   // Issue control
   output logic multi_vp_enable_reg,
   output logic [CTX_W-1:0] sole_ctx_reg
);
   logic multi_vp_enable;
   logic config_state_flag;
   logic shared_tlb_enable;
   logic cache_partition_active;
   logic [1:0] impl_reg;
   logic write_taken;

   // ------------------------------------------------------------
   // Access qualification
   // ------------------------------------------------------------
   // The sharing, partition and implementation fields key off this one term, so that a
   // refused write is refused the same way by all of them.
   always_comb begin
      write_taken = clk_en && reg_wr && master_vp_flag; // RULE13
   end

   // ------------------------------------------------------------
   // Control fields
   // ------------------------------------------------------------
   // Enable and configuration bits: a write without the master flag is dropped.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         multi_vp_enable <= RST_ENABLE; // RULE14
         config_state_flag <= RST_CONFIG;
      end else if (clk_en) begin
         if (master_vp_flag) begin
            if (vp_op == VP_OP_ENABLE) begin
               multi_vp_enable <= 1'b1; // RULE14
            end else if (vp_op == VP_OP_DISABLE) begin
               multi_vp_enable <= 1'b0; // RULE14
            end else if (reg_wr) begin
               multi_vp_enable <= reg_wdata[ENABLE_BIT]; // RULE14
            end
            if (reg_wr) begin
               config_state_flag <= reg_wdata[CONFIG_BIT]; // RULE13
            end
         end
      end
   end

   // Sharing bit looks at the configuration state held before this write.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shared_tlb_enable <= RST_SHARE;
      end else if (write_taken && config_state_flag) begin
         shared_tlb_enable <= HAS_SHARE & reg_wdata[SHARE_BIT]; // RULE5 RULE17
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cache_partition_active <= RST_PART;
         impl_reg <= RST_IMPL;
      end else if (write_taken) begin
         cache_partition_active <= HAS_PARTITION & reg_wdata[PART_BIT]; // RULE17
         impl_reg <= reg_wdata[IMPL_HI:IMPL_LO]; // RULE2
      end
   end

   // ------------------------------------------------------------
   // Read value
   // ------------------------------------------------------------
   // Reserved positions come out zero whatever was last written to them.
   function automatic logic [31:0] compose_read(input logic [1:0] impl,
                                                input logic part,
                                                input logic share,
                                                input logic cfg,
                                                input logic en);
      logic [31:0] w;
      w = '0; // RULE1
      w[IMPL_HI:IMPL_LO] = impl; // RULE2
      w[PART_BIT] = part;
      w[SHARE_BIT] = share;
      w[CONFIG_BIT] = cfg;
      w[ENABLE_BIT] = en;
      return w;
   endfunction : compose_read

   // Registered from the held fields, so a change shows here one edge after it lands.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mt_global_control_reg_q <= '0;
      end else if (clk_en) begin
         mt_global_control_reg_q <= compose_read(impl_reg, cache_partition_active,
                                                 shared_tlb_enable, config_state_flag,
                                                 multi_vp_enable); // RULE1 RULE2
      end
   end

   // ------------------------------------------------------------
   // Cache allocation masks
   // ------------------------------------------------------------
   // A set exclude bit keeps that way out of allocation for the selected processor.
   function automatic logic [NUM_WAYS-1:0] allowed_ways(
      input logic [NUM_VP*NUM_WAYS-1:0] excl,
      input logic [VP_ID_W-1:0] vp
   );
      return ~excl[vp*NUM_WAYS +: NUM_WAYS];
   endfunction : allowed_ways

   // Reset and a clear partition bit both open every way, so a cold cache fills normally.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         icache_alloc_mask_reg <= '1;
         dcache_alloc_mask_reg <= '1;
      end else if (clk_en) begin
         if (cache_partition_active) begin
            icache_alloc_mask_reg <= allowed_ways(icache_way_exclude, alloc_vp); // RULE3
            dcache_alloc_mask_reg <= allowed_ways(dcache_way_exclude, alloc_vp); // RULE3
         end else begin
            icache_alloc_mask_reg <= '1; // RULE4
            dcache_alloc_mask_reg <= '1; // RULE4
         end
      end
   end

   // ------------------------------------------------------------
   // TLB sharing
   // ------------------------------------------------------------
   // Both outputs are registered, so lookups see a change of the sharing bit
   // one edge late; software flushes the TLB around such a change anyway.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         full_tlb_vp_reg <= '0;
         lookup_tag_reg <= '0;
      end else if (clk_en) begin
         full_tlb_vp_reg <= shared_tlb_enable ? vp_tlb_access : '0; // RULE6
         // Dropping the processor number from the tag merges address spaces.
         lookup_tag_reg <= {shared_tlb_enable ? {VP_ID_W{1'b0}} : lookup_vp,
                            lookup_asid}; // RULE7
      end
   end

   tlb_random_pick u_pick (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .wired_count(wired_count),
      .share_on(shared_tlb_enable),
      .vp_sharing(vp_tlb_access),
      .vp_index(vp_index),
      .vp_index_valid(vp_index_valid),
      .own_vp(req_vp),
      .pick_reg(random_tlb_write_index)
   ); // RULE8

   // ------------------------------------------------------------
   // Issue control
   // ------------------------------------------------------------
   // Clearing by a disable or a register write records the issuing context.
   // Other contexts stop only once the registered enable copy falls, so the
   // issuing thread needs a hazard barrier before it relies on being alone.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         multi_vp_enable_reg <= RST_ENABLE;
         sole_ctx_reg <= '0;
      end else if (clk_en) begin
         multi_vp_enable_reg <= multi_vp_enable;
         if (master_vp_flag && multi_vp_enable &&
             ((vp_op == VP_OP_DISABLE) ||
              (vp_op == VP_OP_NONE && reg_wr && !reg_wdata[ENABLE_BIT]))) begin
            sole_ctx_reg <= req_ctx; // RULE15
         end
      end
   end
endmodule : mt_global_control_reg

//--- tb_top.sv
/*
 Self-checking bench for the global control register against an integer model.
 Assumes the design package, the design and the bound checker.
*/
module tb_top import mt_ctl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en, reg_wr, master_vp_flag, multi_vp_enable_reg;
   logic [31:0] reg_wdata, mt_global_control_reg_q, seed, d, r;
   logic [VP_ID_W-1:0] req_vp, alloc_vp, lookup_vp;
   logic [CTX_W-1:0] req_ctx, sole_ctx_reg;
   vp_op_type vp_op;
   logic [NUM_VP*NUM_WAYS-1:0] icache_way_exclude, dcache_way_exclude;
   logic [NUM_WAYS-1:0] icache_alloc_mask_reg, dcache_alloc_mask_reg;
   logic [NUM_VP-1:0] vp_tlb_access, vp_index_valid, full_tlb_vp_reg;
   logic [NUM_VP*TLB_IDX_W-1:0] vp_index;
   logic [TLB_IDX_W-1:0] wired_count, random_tlb_write_index;
   logic [ASID_W-1:0] lookup_asid;
   logic [ASID_W+VP_ID_W-1:0] lookup_tag_reg;
   int en, cfg, shr, part, sole, impl, fail_count, total_checks;
   mt_global_control_reg uut (.clk, .rst_n, .clk_en, .reg_wr, .reg_wdata, .master_vp_flag,
      .req_vp, .req_ctx, .mt_global_control_reg_q, .vp_op, .icache_way_exclude,
      .dcache_way_exclude, .alloc_vp, .icache_alloc_mask_reg, .dcache_alloc_mask_reg,
      .vp_tlb_access, .vp_index, .vp_index_valid, .wired_count, .lookup_vp, .lookup_asid,
      .lookup_tag_reg, .full_tlb_vp_reg, .random_tlb_write_index, .multi_vp_enable_reg,
      .sole_ctx_reg);
   always #2.5 clk = ~clk;
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic complete_run();
      if (fail_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   task automatic check_all();
      logic [3:0] ei;
      logic [3:0] ed;
      logic [ASID_W+VP_ID_W-1:0] tg;
      ei = part ? ~icache_way_exclude[alloc_vp*NUM_WAYS +: NUM_WAYS] : 4'hF;
      ed = part ? ~dcache_way_exclude[alloc_vp*NUM_WAYS +: NUM_WAYS] : 4'hF;
      tg = {shr ? 1'b0 : lookup_vp, lookup_asid};
      chk("ctl", impl * 65536 + part * 8 + shr * 4 + cfg * 2 + en,
          mt_global_control_reg_q);
      chk("enable", en, multi_vp_enable_reg);
      chk("sole", sole, sole_ctx_reg);
      chk("imask", ei, icache_alloc_mask_reg);
      chk("dmask", ed, dcache_alloc_mask_reg);
      chk("tag", tg, lookup_tag_reg);
      chk("full", shr ? vp_tlb_access : 2'h0, full_tlb_vp_reg);
   endtask : check_all
   task automatic wr(input logic [31:0] v, input logic m);
      @(negedge clk);
      reg_wdata = v;
      master_vp_flag = m;
      reg_wr = 1'b1;
      r = rnd();
      req_ctx = r[CTX_W-1:0];
      if (m && clk_en) begin
         if (en != 0 && !v[0]) sole = req_ctx;
         if (cfg != 0) shr = v[SHARE_BIT];
         en = v[0];
         cfg = v[1];
         part = v[3];
         impl = v[IMPL_HI:IMPL_LO];
      end
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
      check_all();
   endtask : wr
   task automatic op(input vp_op_type c, input logic m);
      @(negedge clk);
      vp_op = c;
      master_vp_flag = m;
      r = rnd();
      req_ctx = r[CTX_W-1:0];
      if (m && clk_en) begin
         if (c == VP_OP_DISABLE && en != 0) sole = req_ctx;
         if (c != VP_OP_NONE) en = (c == VP_OP_ENABLE);
      end
      @(negedge clk);
      vp_op = VP_OP_NONE;
      @(negedge clk);
      check_all();
   endtask : op
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      complete_run();
   end
   initial begin
      {seed, en, cfg, shr, part, sole, impl, fail_count, total_checks} = {32'hD52A, 256'h0};
      {clk_en, reg_wr, master_vp_flag, reg_wdata, req_vp, req_ctx, alloc_vp} = {1'b1, 40'h0};
      {icache_way_exclude, dcache_way_exclude, vp_tlb_access, vp_index, vp_index_valid} = '0;
      {lookup_vp, lookup_asid} = '0;
      vp_op = VP_OP_NONE;
      wired_count = 5'h4;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      check_all();
      for (int i = 0; i < 40; i++) begin
         d = rnd() & 32'h3000F;
         if (d[0] && d[1]) d[0] = 1'b0;
         r = rnd();
         {icache_way_exclude, dcache_way_exclude, alloc_vp, lookup_vp, req_vp} = r[18:0];
         r = rnd();
         {lookup_asid, vp_tlb_access} = r[9:0];
         wr(d, rnd() % 4 != 0);
      end
      wr(32'h0, 1'b1);
      op(VP_OP_ENABLE, 1'b1);
      op(VP_OP_DISABLE, 1'b1);
      op(VP_OP_ENABLE, 1'b0);
      wr(32'h2, 1'b1);
      wr(32'h6, 1'b1);
      wr(32'h0, 1'b1);
      wr(32'h4, 1'b0);
      // A write while the clock enable is low must leave every field as it was.
      clk_en = 1'b0;
      wr(32'h8, 1'b1);
      clk_en = 1'b1;
      wr(32'h2, 1'b1);
      wr(32'h4, 1'b1);
      // Both processors share the TLB; after each index change the bench waits 8 cycles, then checks the next 8 picks against their valid index values.
      vp_tlb_access = 2'h3;
      for (int i = 0; i < 12; i++) begin
         r = rnd();
         {vp_index, vp_index_valid} = r[11:0];
         repeat (8) @(negedge clk);
         repeat (8) begin
            @(negedge clk);
            d = 32'h0;
            for (int v = 0; v < NUM_VP; v++) begin
               if (vp_index_valid[v] && random_tlb_write_index == vp_index[v*5 +: 5]) d = 32'h1;
            end
            chk("pick_free", 32'h0, d);
         end
      end
      vp_index_valid = 2'h0;
      check_all();
      complete_run();
   end
endmodule : tb_top

//--- tlb_random_pick.sv
/*
 Random replacement picker for a shared TLB. It steps a free-running
 counter over the unwired entries and skips any entry that a sharing
 virtual processor holds in a valid index register.
 Assumes the index values come from logic on the same clock.
*/
module tlb_random_pick
   import mt_ctl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Configuration
   input wire logic [TLB_IDX_W-1:0] wired_count,
   input wire logic share_on,
   input wire logic [NUM_VP-1:0] vp_sharing,
   input wire logic [NUM_VP*TLB_IDX_W-1:0] vp_index,
   input wire logic [NUM_VP-1:0] vp_index_valid,
   input wire logic [VP_ID_W-1:0] own_vp,
   // Result
   output logic [TLB_IDX_W-1:0] pick_reg
);
   logic [TLB_IDX_W-1:0] count_reg;
   logic [TLB_IDX_W-1:0] count_next;
   logic [NUM_VP-1:0] hit;

   // ------------------------------------------------------------
   // Protected entry compare
   // ------------------------------------------------------------
   function automatic logic [TLB_IDX_W-1:0] wrap_step(input logic [TLB_IDX_W-1:0] v,
                                                    input logic [TLB_IDX_W-1:0] lo);
      logic [TLB_IDX_W-1:0] r;
      r = v + 1'b1;
      if (r < lo) begin
         r = lo;
      end
      return r;
   endfunction : wrap_step

   // Without sharing only the own index matters, as in a private TLB.
   genvar g;
   generate
      for (g = 0; g < NUM_VP; g++) begin : g_hit
         assign hit[g] = vp_index_valid[g] &&
                         (share_on ? vp_sharing[g] : (own_vp == VP_ID_W'(g))) &&
                         (vp_index[g*TLB_IDX_W +: TLB_IDX_W] == count_reg); // RULE8
      end
   endgenerate

   always_comb begin
      count_next = wrap_step(count_reg, wired_count);
   end

   // ------------------------------------------------------------
   // Counter and pick
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (clk_en) begin
         count_reg <= count_next;
      end
   end

   // The pick only updates on an entry free at that edge; it can name a held one after the index values change.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pick_reg <= '1;
      end else if (clk_en && (hit == '0) && (count_reg >= wired_count)) begin
         pick_reg <= count_reg; // RULE8
      end
   end
endmodule : tlb_random_pick
